/* src/bzm_top.sv */
// bzm_top: two-note buzzer and melody controller with APB register access
// assumes one 10 MHz clock, synchronous active-low reset, single APB master
// Behaviour
// [R01] power window expiry sets a sticky flag; irq only while its enable is set; a set irq_mask bit 2 also raises irq without it
// [R02] config byte bits 7..0: enable, polarity, irq enables, end flags, starts
// [R03] config read bits 1..0 show note B and note A playing, not starts
// [R04] each note-end irq enable lets that note's completion raise an interrupt
// [R05] note B end flag sets on completion only if its irq enable is one
// [R06] note A end flag sets on completion only if its irq enable is one
// [R07] end flags clear only by writing zero; writing one keeps them
// [R08] writing one to note B start begins note B; zero ignored; self clears
// [R09] writing one to note A start begins note A; zero ignored; self clears
// [R10] both starts in one write play note A then note B at once
// [R11] note B playing reads one while note B is sounding
// [R12] note A playing reads one while note A is sounding
// [R13] tone is clock over 32 or 64 over pitch plus one
// [R14] length and gap are counts of a 1, 2, 4 or 8 ms unit
// [R15] power window timer starts on any note start, counts in the same unit
// [R16] enable low holds output idle and ignores starts; polarity inverts output; disabled pin is held low whatever the polarity
// [R17] tone sounds for length, idle for gap, then the note is complete
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module bzm_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // buzzer and interrupt
    output logic buzzer_output_pin,
    output logic irq
);
    localparam int TICK_W = 14;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(bzm_pkg::BZM_TICK_CYCLES - 1);

    // register state
    bzm_pkg::bzm_note_type note_a, note_b, next_note_a, next_note_b;
    logic [7:0] config_reg, next_config;
    logic [7:0] power_window_length, next_pw_len;
    logic [7:0] time_unit_reg, next_time_unit;
    logic [bzm_pkg::BZM_EV_N-1:0] irq_status, next_irq_status, irq_mask, next_irq_mask;
    // sequencer state
    bzm_pkg::bzm_phase_type phase, next_phase;
    logic cur_b, next_cur_b, b_pending, next_b_pending;
    logic [7:0] phase_cnt, next_phase_cnt;
    logic [TICK_W-1:0] ms_cnt, next_ms_cnt;
    logic [2:0] unit_cnt, next_unit_cnt;
    logic pw_run, next_pw_run;
    logic [7:0] pw_cnt, next_pw_cnt;
    // bus and outputs
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_pin, next_irq;
    logic wr, rd, hit, done_a, done_b, pw_done, unit_tick, tone_run, wave, go_a, go_b;
    logic [15:0] idx;
    logic [7:0] wb, rb;

    bzm_tone_gen u_tone (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(tone_run),
        .base_sel(time_unit_reg[bzm_pkg::BZM_UNIT_BASE]),
        .pitch(cur_b ? note_b.pitch : note_a.pitch),
        .wave(wave)
    );

    // address decode: byte address is the printed index times four
    always_comb begin
        idx = paddr[17:2];
        wb = pwdata[7:0];
        wr = psel && penable && pwrite && !pready && pstrb[0];
        rd = psel && penable && !pwrite && !pready;
        hit = (paddr[1:0] == 2'h0) && idx >= bzm_pkg::BZM_IDX_A_PITCH_LO
            && idx <= bzm_pkg::BZM_IDX_IRQ_MASK;
    end

    // unit tick: 1 ms base divided further by 1, 2, 4 or 8
    always_comb begin
        next_ms_cnt = (ms_cnt == TICK_LAST) ? '0 : ms_cnt + 1'b1;
        next_unit_cnt = unit_cnt;
        unit_tick = 1'b0;
        if (ms_cnt == TICK_LAST) begin
            next_unit_cnt = unit_cnt + 3'h1;
            unit_sel: unique case (time_unit_reg[bzm_pkg::BZM_UNIT_HI:bzm_pkg::BZM_UNIT_LO])
                2'b00: unit_tick = 1'b1; // [R14]
                2'b01: unit_tick = unit_cnt[0];
                2'b10: unit_tick = &unit_cnt[1:0];
                2'b11: unit_tick = &unit_cnt;
            endcase
        end
    end

    // note sequencer: tone for length units, idle for gap units
    always_comb begin
        next_phase = phase;
        next_cur_b = cur_b;
        next_b_pending = b_pending;
        next_phase_cnt = phase_cnt;
        done_a = 1'b0;
        done_b = 1'b0;
        go_a = wr && hit && idx == bzm_pkg::BZM_IDX_CONFIG && config_reg[bzm_pkg::BZM_CFG_ENABLE]
            && wb[bzm_pkg::BZM_CFG_A_GO] && phase == bzm_pkg::BZM_IDLE; // [R09] [R16]
        go_b = wr && hit && idx == bzm_pkg::BZM_IDX_CONFIG && config_reg[bzm_pkg::BZM_CFG_ENABLE]
            && wb[bzm_pkg::BZM_CFG_B_GO] && phase == bzm_pkg::BZM_IDLE; // [R08] [R16]
        seq: unique case (phase)
            bzm_pkg::BZM_IDLE: begin
                if (go_a || go_b) begin
                    next_phase = bzm_pkg::BZM_TONE;
                    next_cur_b = !go_a; // [R10]
                    next_b_pending = go_a && go_b; // [R10]
                    next_phase_cnt = 8'h00;
                end
            end
            bzm_pkg::BZM_TONE: begin
                if ((cur_b ? note_b.length : note_a.length) == phase_cnt) begin
                    next_phase = bzm_pkg::BZM_GAP; // [R17]
                    next_phase_cnt = 8'h00;
                end else if (unit_tick) begin
                    next_phase_cnt = phase_cnt + 8'h01;
                end
            end
            bzm_pkg::BZM_GAP: begin
                if ((cur_b ? note_b.gap : note_a.gap) == phase_cnt) begin
                    done_a = !cur_b; // [R17]
                    done_b = cur_b;
                    next_phase_cnt = 8'h00;
                    if (b_pending) begin
                        next_phase = bzm_pkg::BZM_TONE; // [R10]
                        next_cur_b = 1'b1;
                        next_b_pending = 1'b0;
                    end else begin
                        next_phase = bzm_pkg::BZM_IDLE;
                    end
                end else if (unit_tick) begin
                    next_phase_cnt = phase_cnt + 8'h01;
                end
            end
            default: next_phase = bzm_pkg::BZM_IDLE;
        endcase
        if (!config_reg[bzm_pkg::BZM_CFG_ENABLE]) begin
            next_phase = bzm_pkg::BZM_IDLE; // [R16]
            next_b_pending = 1'b0;
        end
        tone_run = phase == bzm_pkg::BZM_TONE;
    end

    // power window timer, restarted by any accepted start
    always_comb begin
        next_pw_run = pw_run;
        next_pw_cnt = pw_cnt;
        pw_done = 1'b0;
        if (go_a || go_b) begin
            next_pw_run = 1'b1; // [R15]
            next_pw_cnt = 8'h00;
        end else if (pw_run) begin
            if (pw_cnt == power_window_length) begin
                next_pw_run = 1'b0;
                pw_done = 1'b1; // [R01]
            end else if (unit_tick) begin
                next_pw_cnt = pw_cnt + 8'h01; // [R15]
            end
        end
    end

    // register writes; hardware sets beat software clears
    always_comb begin
        next_note_a = note_a;
        next_note_b = note_b;
        next_config = config_reg;
        next_pw_len = power_window_length;
        next_time_unit = time_unit_reg;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (wr && hit) begin
            regs: unique case (idx)
                bzm_pkg::BZM_IDX_A_PITCH_LO: next_note_a.pitch[7:0] = wb;
                bzm_pkg::BZM_IDX_A_PITCH_HI: next_note_a.pitch[11:8] = wb[3:0];
                bzm_pkg::BZM_IDX_A_LENGTH: next_note_a.length = wb;
                bzm_pkg::BZM_IDX_A_GAP: next_note_a.gap = wb;
                bzm_pkg::BZM_IDX_B_PITCH_LO: next_note_b.pitch[7:0] = wb;
                bzm_pkg::BZM_IDX_B_PITCH_HI: next_note_b.pitch[11:8] = wb[3:0];
                bzm_pkg::BZM_IDX_B_LENGTH: next_note_b.length = wb;
                bzm_pkg::BZM_IDX_B_GAP: next_note_b.gap = wb;
                bzm_pkg::BZM_IDX_CONFIG: begin
                    next_config[7:4] = wb[7:4]; // [R02]
                    next_config[3:2] = config_reg[3:2] & wb[3:2]; // [R07]
                end
                bzm_pkg::BZM_IDX_POWER_WINDOW: next_pw_len = wb;
                bzm_pkg::BZM_IDX_TIME_UNIT: begin
                    next_time_unit = {wb[7:6], 1'b0, wb[4], 2'b00, wb[1],
                        time_unit_reg[0] & wb[0]};
                end
                bzm_pkg::BZM_IDX_IRQ_STATUS: next_irq_status = irq_status & ~wb[2:0];
                bzm_pkg::BZM_IDX_IRQ_MASK: next_irq_mask = wb[2:0];
                default: next_irq_mask = irq_mask;
            endcase
        end
        if (done_a && config_reg[bzm_pkg::BZM_CFG_A_IRQ_EN]) begin
            next_config[bzm_pkg::BZM_CFG_A_FLAG] = 1'b1; // [R06]
        end
        if (done_b && config_reg[bzm_pkg::BZM_CFG_B_IRQ_EN]) begin
            next_config[bzm_pkg::BZM_CFG_B_FLAG] = 1'b1; // [R05]
        end
        if (pw_done) begin
            next_time_unit[bzm_pkg::BZM_UNIT_PW_FLAG] = 1'b1; // [R01]
        end
        next_irq_status[bzm_pkg::BZM_EV_A_END] = next_irq_status[bzm_pkg::BZM_EV_A_END] | done_a;
        next_irq_status[bzm_pkg::BZM_EV_B_END] = next_irq_status[bzm_pkg::BZM_EV_B_END] | done_b;
        next_irq_status[bzm_pkg::BZM_EV_PW_END] = next_irq_status[bzm_pkg::BZM_EV_PW_END] | pw_done;
    end

    // read mux, one-wait-state answer, output pin and interrupt line
    always_comb begin
        rb = 8'h00;
        rd_mux: unique case (idx)
            bzm_pkg::BZM_IDX_A_PITCH_LO: rb = note_a.pitch[7:0];
            bzm_pkg::BZM_IDX_A_PITCH_HI: rb = {4'h0, note_a.pitch[11:8]};
            bzm_pkg::BZM_IDX_A_LENGTH: rb = note_a.length;
            bzm_pkg::BZM_IDX_A_GAP: rb = note_a.gap;
            bzm_pkg::BZM_IDX_B_PITCH_LO: rb = note_b.pitch[7:0];
            bzm_pkg::BZM_IDX_B_PITCH_HI: rb = {4'h0, note_b.pitch[11:8]};
            bzm_pkg::BZM_IDX_B_LENGTH: rb = note_b.length;
            bzm_pkg::BZM_IDX_B_GAP: rb = note_b.gap;
            bzm_pkg::BZM_IDX_CONFIG: rb = {config_reg[7:2],
                tone_run && cur_b, tone_run && !cur_b}; // [R03] [R11] [R12]
            bzm_pkg::BZM_IDX_POWER_WINDOW: rb = power_window_length;
            bzm_pkg::BZM_IDX_TIME_UNIT: rb = time_unit_reg;
            bzm_pkg::BZM_IDX_IRQ_STATUS: rb = {5'h00, irq_status};
            bzm_pkg::BZM_IDX_IRQ_MASK: rb = {5'h00, irq_mask};
            default: rb = 8'h00;
        endcase
        next_pready = psel && penable && !pready;
        next_pslverr = psel && penable && !pready && !hit;
        next_prdata = (rd && hit) ? {24'h000000, rb} : 32'h00000000;
        next_pin = config_reg[bzm_pkg::BZM_CFG_ENABLE]
            && ((tone_run && wave) ^ config_reg[bzm_pkg::BZM_CFG_POLARITY]); // [R16]
        next_irq = |(next_irq_status & irq_mask)
            || (next_config[bzm_pkg::BZM_CFG_A_FLAG] && next_config[bzm_pkg::BZM_CFG_A_IRQ_EN])
            || (next_config[bzm_pkg::BZM_CFG_B_FLAG] && next_config[bzm_pkg::BZM_CFG_B_IRQ_EN])
            || (next_time_unit[bzm_pkg::BZM_UNIT_PW_FLAG]
                && next_time_unit[bzm_pkg::BZM_UNIT_PW_IRQ_EN]); // [R01] [R04]
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            note_a <= '0;
            note_b <= '0;
            config_reg <= bzm_pkg::BZM_RESET_BYTE;
            power_window_length <= bzm_pkg::BZM_RESET_BYTE;
            time_unit_reg <= bzm_pkg::BZM_RESET_BYTE;
            irq_status <= bzm_pkg::BZM_RESET_EV;
            irq_mask <= bzm_pkg::BZM_RESET_EV;
            phase <= bzm_pkg::BZM_IDLE;
            cur_b <= 1'b0;
            b_pending <= 1'b0;
            phase_cnt <= 8'h00;
            ms_cnt <= '0;
            unit_cnt <= 3'h0;
            pw_run <= 1'b0;
            pw_cnt <= 8'h00;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            buzzer_output_pin <= 1'b0;
            irq <= 1'b0;
        end else begin
            note_a <= next_note_a;
            note_b <= next_note_b;
            config_reg <= next_config;
            power_window_length <= next_pw_len;
            time_unit_reg <= next_time_unit;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            phase <= next_phase;
            cur_b <= next_cur_b;
            b_pending <= next_b_pending;
            phase_cnt <= next_phase_cnt;
            ms_cnt <= next_ms_cnt;
            unit_cnt <= next_unit_cnt;
            pw_run <= next_pw_run;
            pw_cnt <= next_pw_cnt;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            buzzer_output_pin <= next_pin;
            irq <= next_irq;
        end
    end

    sequence s_end_a;
        phase == bzm_pkg::BZM_GAP && !cur_b && done_a;
    endsequence

    a_flag_a_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R06]
        s_end_a ##0 config_reg[bzm_pkg::BZM_CFG_A_IRQ_EN] |=> config_reg[2])
        else $error("note A end flag not set");
    a_flag_b_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R05]
        done_b && config_reg[bzm_pkg::BZM_CFG_B_IRQ_EN] |=> config_reg[3])
        else $error("note B end flag not set");
    a_flag_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R07]
        config_reg[2] && !(wr && idx == bzm_pkg::BZM_IDX_CONFIG && !wb[2])
        |=> config_reg[2]) else $error("end flag dropped without a zero write");
    a_seq_ab: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
        go_a && go_b |=> tone_run && !cur_b && b_pending)
        else $error("dual start did not begin with note A");
    a_b_follows: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
        s_end_a ##0 b_pending && config_reg[7] |=> tone_run && cur_b)
        else $error("note B did not follow note A");
    a_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R09]
        go_a |=> tone_run && !cur_b) else $error("note A start ignored");
    a_start_b: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R08]
        go_b && !go_a |=> tone_run && cur_b) else $error("note B start ignored");
    a_disabled_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R16]
        !config_reg[7] && !$past(config_reg[7]) |=> buzzer_output_pin == 1'b0 && !tone_run)
        else $error("output active while disabled");
    a_pw_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R01]
        pw_done |=> time_unit_reg[0] ##1 (time_unit_reg[0] || $past(wr)))
        else $error("power window flag not set");
    a_pw_start: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R15]
        go_a || go_b |=> pw_run && pw_cnt == 8'h00) else $error("window timer not started");
endmodule

/* src/bzm_pkg.sv */
// bzm_pkg: register map, field positions, reset values and timing for the buzzer block
// assumes a 10 MHz system clock and an APB slave with 32-bit data
package bzm_pkg;
    // register indices (printed offsets are not all multiples of four: byte address is index * 4)
    localparam logic [15:0] BZM_IDX_A_PITCH_LO = 16'hA040;
    localparam logic [15:0] BZM_IDX_A_PITCH_HI = 16'hA041;
    localparam logic [15:0] BZM_IDX_A_LENGTH = 16'hA042;
    localparam logic [15:0] BZM_IDX_A_GAP = 16'hA043;
    localparam logic [15:0] BZM_IDX_B_PITCH_LO = 16'hA044;
    localparam logic [15:0] BZM_IDX_B_PITCH_HI = 16'hA045;
    localparam logic [15:0] BZM_IDX_B_LENGTH = 16'hA046;
    localparam logic [15:0] BZM_IDX_B_GAP = 16'hA047;
    localparam logic [15:0] BZM_IDX_CONFIG = 16'hA048;
    localparam logic [15:0] BZM_IDX_POWER_WINDOW = 16'hA049;
    localparam logic [15:0] BZM_IDX_TIME_UNIT = 16'hA04A;
    localparam logic [15:0] BZM_IDX_IRQ_STATUS = 16'hA04B;
    localparam logic [15:0] BZM_IDX_IRQ_MASK = 16'hA04C;
    localparam int BZM_ADDR_W = 18;
    // config register fields
    localparam int BZM_CFG_ENABLE = 7;
    localparam int BZM_CFG_POLARITY = 6;
    localparam int BZM_CFG_B_IRQ_EN = 5;
    localparam int BZM_CFG_A_IRQ_EN = 4;
    localparam int BZM_CFG_B_FLAG = 3;
    localparam int BZM_CFG_A_FLAG = 2;
    localparam int BZM_CFG_B_GO = 1;
    localparam int BZM_CFG_A_GO = 0;
    // time unit register fields
    localparam int BZM_UNIT_HI = 7;
    localparam int BZM_UNIT_LO = 6;
    localparam int BZM_UNIT_BASE = 4;
    localparam int BZM_UNIT_PW_IRQ_EN = 1;
    localparam int BZM_UNIT_PW_FLAG = 0;
    // event bits of the irq status / mask registers
    localparam int BZM_EV_A_END = 0;
    localparam int BZM_EV_B_END = 1;
    localparam int BZM_EV_PW_END = 2;
    localparam int BZM_EV_N = 3;
    localparam logic [7:0] BZM_RESET_BYTE = 8'h00;
    localparam logic [BZM_EV_N-1:0] BZM_RESET_EV = 3'h0;
    // timing: one millisecond base tick from the system clock
    localparam int BZM_CLK_HZ = 10000000;
    localparam int BZM_TICK_US = 1000;
    localparam int BZM_TICK_CYCLES = BZM_CLK_HZ / 1000000 * BZM_TICK_US;
    localparam int BZM_BASE_DIV_LO = 32;
    localparam int BZM_BASE_DIV_HI = 64;

    typedef enum logic [1:0] {
        BZM_IDLE = 2'b00,
        BZM_TONE = 2'b01,
        BZM_GAP = 2'b10
    } bzm_phase_type;

    // settings of one note, carried as a group
    typedef struct packed {
        logic [11:0] pitch;
        logic [7:0] length;
        logic [7:0] gap;
    } bzm_note_type;
endpackage

/* src/bzm_tone_gen.sv */
// bzm_tone_gen: square wave at clk / base / (pitch + 1), one toggle per half period
// assumes run is a level from the same clock; output parks low while run is low
`timescale 1ns/10ps
module bzm_tone_gen (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic base_sel,
    input wire logic [11:0] pitch,
    // tone
    output logic wave
);
    logic [5:0] pre;
    logic [11:0] div;
    logic next_wave;
    logic [5:0] next_pre;
    logic [11:0] next_div;
    logic pre_wrap;

    // half of base divider per toggle gives the full base per period
    always_comb begin
        pre_wrap = base_sel ? (pre == 6'(bzm_pkg::BZM_BASE_DIV_HI / 2 - 1))
            : (pre == 6'(bzm_pkg::BZM_BASE_DIV_LO / 2 - 1));
        next_pre = pre + 6'h01;
        next_div = div;
        next_wave = wave;
        if (pre_wrap) begin
            next_pre = 6'h00;
            if (div >= pitch) begin
                next_div = 12'h000;
                next_wave = ~wave; // [R13]
            end else begin
                next_div = div + 12'h001;
            end
        end
        if (!run) begin
            next_pre = 6'h00;
            next_div = 12'h000;
            next_wave = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pre <= 6'h00;
            div <= 12'h000;
            wave <= 1'b0;
        end else begin
            pre <= next_pre;
            div <= next_div;
            wave <= next_wave;
        end
    end

    // once run drops the wave parks low, so the pin rests at its idle level
    a_tone_park: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R17]
        !$past(run) |-> wave == 1'b0)
        else $error("tone toggled outside a run");
endmodule

/* verification/bzm_piezo.sv */
// bzm_piezo: behavioural piezo element, counts level changes of its drive
// assumes the drive is a registered pin from the same clock domain
`timescale 1ns/10ps
module bzm_piezo (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // buzzer drive
    input wire logic drive,
    // observation
    output int edges
);
    logic last;

    // each change of drive moves the membrane once
    always_ff @(posedge clk_sys) begin
        last <= drive;
        if (!rst_n) begin
            edges <= 0;
        end else if (drive !== last) begin
            edges <= edges + 1;
        end
    end
endmodule

/* verification/testbench.sv */
// testbench: register-level tests of the buzzer block through APB
// assumes 10 MHz clock, reads and writes one word per register index
`timescale 1ns/10ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic buzzer_output_pin;
    logic irq;
    int edges;
    int failures = 0;
    int num_checks = 0;
    logic [31:0] rd;
    logic err;
    time t0;
    int dur;

    bzm_top u_bzm_top (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .buzzer_output_pin(buzzer_output_pin), .irq(irq));
    bzm_piezo u_bzm_piezo (.clk_sys(clk_sys), .rst_n(rst_n), .drive(buzzer_output_pin),
        .edges(edges));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            report_and_stop();
        end
    endtask

    task automatic rd_chk(input string name, input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(name, rd, {24'h000000, exp});
    endtask

    // poll config until the playing bits match; a note lasts a few ms at most
    task automatic wait_play(input logic [1:0] exp);
        int n;
        n = 0;
        apb(1'b0, bzm_pkg::BZM_IDX_CONFIG, 8'h00);
        while (rd[1:0] !== exp && n < 12000) begin
            apb(1'b0, bzm_pkg::BZM_IDX_CONFIG, 8'h00);
            n++;
        end
        if (n >= 12000) begin
            failures++;
            report_and_stop();
        end
    endtask

    // cycles between two consecutive pin changes while a tone sounds
    task automatic half_period(input int exp);
        int n;
        logic last;
        n = 0;
        @(posedge clk_sys);
        last = buzzer_output_pin;
        while (buzzer_output_pin === last && n < 30000) begin
            @(posedge clk_sys);
            n++;
        end
        last = buzzer_output_pin;
        n = 0;
        while (buzzer_output_pin === last && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        check("half period", n, exp);
    endtask

    // a hung note must not stall the run
    initial begin
        repeat (95000) @(posedge clk_sys);
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk("config reset", bzm_pkg::BZM_IDX_CONFIG, 8'h00);
        rd_chk("time unit reset", bzm_pkg::BZM_IDX_TIME_UNIT, 8'h00);
        rd_chk("pitch reset", bzm_pkg::BZM_IDX_A_PITCH_LO, 8'h00);
        apb(1'b0, 16'hA04D, 8'h00);
        check("unmapped error", {31'h0, err}, 32'h1);
        // starts while disabled are dropped
        apb(1'b1, bzm_pkg::BZM_IDX_A_LENGTH, 8'h02);
        apb(1'b1, bzm_pkg::BZM_IDX_CONFIG, 8'h03);
        rd_chk("disabled start", bzm_pkg::BZM_IDX_CONFIG, 8'h00);
        check("silent pin", edges, 32'h0);
        apb(1'b1, bzm_pkg::BZM_IDX_CONFIG, 8'hC0);
        rd_chk("polarity cfg", bzm_pkg::BZM_IDX_CONFIG, 8'hC0);
        check("inverted idle", {31'h0, buzzer_output_pin}, 32'h1);
        apb(1'b1, bzm_pkg::BZM_IDX_CONFIG, 8'h80);
        rd_chk("normal cfg", bzm_pkg::BZM_IDX_CONFIG, 8'h80);
        check("normal idle", {31'h0, buzzer_output_pin}, 32'h0);
        // two-note sequence with both end irqs enabled
        apb(1'b1, bzm_pkg::BZM_IDX_A_PITCH_LO, 8'h03);
        apb(1'b1, bzm_pkg::BZM_IDX_B_PITCH_LO, 8'h07);
        apb(1'b1, bzm_pkg::BZM_IDX_B_LENGTH, 8'h02);
        apb(1'b1, bzm_pkg::BZM_IDX_POWER_WINDOW, 8'h01);
        apb(1'b1, bzm_pkg::BZM_IDX_CONFIG, 8'hB3);
        rd_chk("a plays first", bzm_pkg::BZM_IDX_CONFIG, 8'hB1);
        half_period(16 * 4);
        wait_play(2'b10);
        check("a done b plays", rd, 32'h000000B6);
        half_period(16 * 8);
        wait_play(2'b00);
        // the end flag lands a cycle after the tone stops, so read again
        rd_chk("both done", bzm_pkg::BZM_IDX_CONFIG, 8'hBC);
        check("note irq", {31'h0, irq}, 32'h1);
        rd_chk("window flag", bzm_pkg::BZM_IDX_TIME_UNIT, 8'h01);
        apb(1'b1, bzm_pkg::BZM_IDX_CONFIG, 8'hBC);
        rd_chk("flags kept", bzm_pkg::BZM_IDX_CONFIG, 8'hBC);
        apb(1'b1, bzm_pkg::BZM_IDX_CONFIG, 8'h80);
        rd_chk("flags cleared", bzm_pkg::BZM_IDX_CONFIG, 8'h80);
        apb(1'b1, bzm_pkg::BZM_IDX_TIME_UNIT, 8'h00);
        rd_chk("window cleared", bzm_pkg::BZM_IDX_TIME_UNIT, 8'h00);
        rd_chk("irq status", bzm_pkg::BZM_IDX_IRQ_STATUS, 8'h07);
        apb(1'b1, bzm_pkg::BZM_IDX_IRQ_STATUS, 8'h07);
        rd_chk("status cleared", bzm_pkg::BZM_IDX_IRQ_STATUS, 8'h00);
        apb(1'b1, bzm_pkg::BZM_IDX_IRQ_MASK, 8'h07);
        rd_chk("irq mask", bzm_pkg::BZM_IDX_IRQ_MASK, 8'h07);
        check("irq low", {31'h0, irq}, 32'h0);
        // single note, 2 ms unit on the slower base, no end irq enable
        apb(1'b1, bzm_pkg::BZM_IDX_TIME_UNIT, 8'h50);
        apb(1'b1, bzm_pkg::BZM_IDX_CONFIG, 8'h81);
        t0 = $time;
        half_period(32 * 4);
        wait_play(2'b00);
        check("no flag", rd, 32'h00000080);
        check("pin toggled", {31'h0, edges > 20}, 32'h1);
        // two 2 ms units outlast 1.5 ms whatever the phase of the free divider
        dur = int'(($time - t0) / 100);
        check("two ms unit", {31'h0, dur > 3 * bzm_pkg::BZM_TICK_CYCLES / 2}, 32'h1);
        report_and_stop();
    end
endmodule
